// *** design/ioexp_cfg.svh ***
// Offsets, field positions, reset values and timing for the expander pair
`ifndef IOEXP_CFG_SVH
`define IOEXP_CFG_SVH
`define REG_PIN_LEVEL_LO 3'h0
`define REG_PIN_LEVEL_HI 3'h1
`define REG_DRIVE_LATCH_LO 3'h2
`define REG_DRIVE_LATCH_HI 3'h3
`define REG_INVERT_SEL_LO 3'h4
`define REG_INVERT_SEL_HI 3'h5
`define REG_DIRECTION_LO 3'h6
`define REG_DIRECTION_HI 3'h7
`define RESET_DRIVE_LATCH 8'hFF
`define RESET_INVERT_SEL 8'h00
`define RESET_DIRECTION 8'hFF
`define RESET_PIN_LEVEL 8'h00
`define DEV_ADDR_FIXED 5'h1D
`define RW_WRITE 1'b0
`define RW_READ 1'b1
`define HOST_CTRL 5'h00
`define HOST_TARGET 5'h04
`define HOST_CMD 5'h08
`define HOST_WDATA 5'h0C
`define HOST_RDATA 5'h10
`define HOST_STATUS 5'h14
`define CTRL_GO 0
`define CTRL_READ 1
`define CTRL_COUNT_LSB 2
`define STAT_BUSY 0
`define STAT_NACK 1
`define RESET_TARGET 7'h74
`define LINK_QUARTER_NS 625
`define CORE_PERIOD_PS 4000
`endif

// *** design/ioexp_pkg.sv ***
// Types shared by both ends of the expander link
package ioexp_pkg;
	typedef logic [2:0] reg_sel_t;
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_RX = 3'h1,
		D_RX_ACK = 3'h2,
		D_TX = 3'h3,
		D_TX_ACK = 3'h4,
		D_WAIT = 3'h5
	} dev_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_START = 2'h1,
		H_BIT = 2'h2,
		H_STOP = 2'h3
	} host_state_t;
endpackage

// *** design/ioexp_if.sv ***
// Two-wire link between controller and expander, wired-and with pull-ups
`timescale 1ns/1ps
interface ioexp_if;
	logic scl_oe_n;
	logic sda_host_oe_n;
	logic sda_dev_oe_n;
	logic scl;
	logic sda;
	// A released line floats high through the pull-up
	assign scl = scl_oe_n;
	assign sda = sda_host_oe_n & sda_dev_oe_n;
	modport host (output scl_oe_n, output sda_host_oe_n, input scl, input sda);
	modport device (output sda_dev_oe_n, input scl, input sda);
endinterface

// *** design/sync2.sv ***
// Two-flop synchroniser for levels from outside the core clock domain
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1) begin : g_check
		$error("sync2 needs WIDTH of at least one");
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stage1 <= INIT;
			sync_out <= INIT;
		end else if (ce) begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** design/ioexp_device.sv ***
// Expander end: two-wire slave, eight byte registers, 16 pins, interrupt
`timescale 1ns/1ps
`include "ioexp_cfg.svh"
module ioexp_device import ioexp_pkg::*; (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	// Two-wire link
	ioexp_if.device link,
	// Port pins, low port in bits 7:0
	input wire logic [15:0] gpio_in,
	output logic [15:0] gpio_out,
	output logic [15:0] gpio_oe_n,
	// Address straps
	input wire logic addr_strap0,
	input wire logic addr_strap1,
	// Open-drain interrupt, enable low pulls the line low
	output logic int_oe_n
);
	logic [19:0] synced;
	logic [15:0] pins_s;
	logic [15:0] pins_d;
	logic [1:0] strap_s;
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic addr_match;
	logic rx_done;
	dev_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] shift;
	logic [1:0] byte_cnt;
	logic rd_mode;
	logic active;
	logic sda_oe_n;
	reg_sel_t cmd_reg;
	reg_sel_t ptr;
	logic [15:0] pin_level;
	logic [15:0] drive_latch;
	logic [15:0] invert_sel;
	logic [15:0] direction;
	logic [15:0] live_input;
	logic [1:0] irq;

	sync2 #(
		.WIDTH(20),
		.INIT({2'h0, 2'h3, 16'h0000})
	) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.async_in({addr_strap1, addr_strap0, link.sda, link.scl, gpio_in}),
		.sync_out(synced)
	);

	assign strap_s = synced[19:18];
	assign sda_s = synced[17];
	assign scl_s = synced[16];
	assign pins_s = synced[15:0];

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			pins_d <= 16'h0000;
		end else if (ce) begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			pins_d <= pins_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	assign addr_match = shift[7:1] == {`DEV_ADDR_FIXED, strap_s};
	assign rx_done = (state == D_RX) && scl_fall && (bitcnt == 4'h8);
	// Inversion only applies to pins set up as inputs
	assign live_input = pins_s ^ (invert_sel & direction);

	function automatic logic [7:0] reg_value(input reg_sel_t sel);
		case (sel)
			`REG_PIN_LEVEL_LO: reg_value = pin_level[7:0];
			`REG_PIN_LEVEL_HI: reg_value = pin_level[15:8];
			`REG_DRIVE_LATCH_LO: reg_value = drive_latch[7:0];
			`REG_DRIVE_LATCH_HI: reg_value = drive_latch[15:8];
			`REG_INVERT_SEL_LO: reg_value = invert_sel[7:0];
			`REG_INVERT_SEL_HI: reg_value = invert_sel[15:8];
			`REG_DIRECTION_LO: reg_value = direction[7:0];
			default: reg_value = direction[15:8];
		endcase
	endfunction

	// Byte engine; sda only changes after a detected scl fall
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= D_IDLE;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			byte_cnt <= 2'h0;
			rd_mode <= 1'b0;
			active <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (ce) begin
			if (stop_cond) begin
				state <= D_IDLE;
				active <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (start_cond) begin
				state <= D_RX;
				bitcnt <= 4'h0;
				byte_cnt <= 2'h0;
				rd_mode <= 1'b0;
				sda_oe_n <= 1'b1;
			end else begin
				case (state)
				D_RX: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end else if (rx_done) begin
						if (byte_cnt == 2'h0 && !addr_match) begin
							state <= D_IDLE;
							active <= 1'b0;
						end else begin
							state <= D_RX_ACK;
							sda_oe_n <= 1'b0;
							if (byte_cnt == 2'h0) begin
								active <= 1'b1;
								rd_mode <= shift[0] == `RW_READ;
							end
							// Saturates: every later byte is data
							if (byte_cnt != 2'h2) begin
								byte_cnt <= byte_cnt + 2'h1;
							end
						end
					end
				end
				D_RX_ACK: begin
					if (scl_fall) begin
						if (rd_mode) begin
							shift <= reg_value(ptr);
							sda_oe_n <= reg_value(ptr) >> 7 != 8'h00;
							bitcnt <= 4'h1;
							state <= D_TX;
						end else begin
							sda_oe_n <= 1'b1;
							bitcnt <= 4'h0;
							state <= D_RX;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							sda_oe_n <= 1'b1;
							state <= D_TX_ACK;
						end else begin
							sda_oe_n <= shift[6];
							shift <= {shift[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				D_TX_ACK: begin
					if (scl_rise && sda_s) begin
						state <= D_WAIT;
					end else if (scl_fall) begin
						shift <= reg_value(ptr);
						sda_oe_n <= reg_value(ptr) >> 7 != 8'h00;
						bitcnt <= 4'h1;
						state <= D_TX;
					end
				end
				D_IDLE, D_WAIT: begin
				end
				default: state <= D_IDLE;
				endcase
			end
		end
	end

	// Pointer and configuration registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			drive_latch <= {2{`RESET_DRIVE_LATCH}};
			invert_sel <= {2{`RESET_INVERT_SEL}};
			direction <= {2{`RESET_DIRECTION}};
			cmd_reg <= `REG_PIN_LEVEL_LO;
			ptr <= `REG_PIN_LEVEL_LO;
		end else if (ce) begin
			if (start_cond) begin
				if (active) begin
					cmd_reg <= ptr;
				end else begin
					ptr <= cmd_reg;
				end
			end else if (rx_done && byte_cnt == 2'h1 && addr_ok_cmd()) begin
				cmd_reg <= shift[2:0];
				ptr <= shift[2:0];
			end else if (rx_done && byte_cnt == 2'h2) begin
				case (ptr)
				`REG_DRIVE_LATCH_LO: drive_latch[7:0] <= shift;
				`REG_DRIVE_LATCH_HI: drive_latch[15:8] <= shift;
				`REG_INVERT_SEL_LO: invert_sel[7:0] <= shift;
				`REG_INVERT_SEL_HI: invert_sel[15:8] <= shift;
				`REG_DIRECTION_LO: direction[7:0] <= shift;
				`REG_DIRECTION_HI: direction[15:8] <= shift;
				default: begin
				end
				endcase
				ptr <= ptr ^ 3'h1;
			end else if (state == D_TX_ACK && scl_rise) begin
				ptr <= ptr ^ 3'h1;
			end
		end
	end

	function automatic logic addr_ok_cmd();
		addr_ok_cmd = !rd_mode;
	endfunction

	// Input registers load at the acknowledge clock rise
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_level <= {2{`RESET_PIN_LEVEL}};
		end else if (ce && scl_rise) begin
			if (state == D_RX_ACK || state == D_TX_ACK) begin
				pin_level <= live_input;
			end
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic flag;
		logic clr;
		logic [7:0] change;
		// Output pins cannot raise an interrupt
		assign change = (pins_s[p*8 +: 8] ^ pins_d[p*8 +: 8])
			& direction[p*8 +: 8];
		assign clr = state == D_TX_ACK && scl_rise && ptr[2:1] == 2'h0
			&& ptr[0] == 1'(p);
		always_ff @(posedge core_clk) begin
			if (!nrst) begin
				flag <= 1'b0;
			end else if (ce) begin
				// A pin edge in the clearing cycle wins
				if (|change) begin
					flag <= 1'b1;
				end else if (clr) begin
					flag <= 1'b0;
				end
			end
		end
		assign irq[p] = flag;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			int_oe_n <= 1'b1;
		end else if (ce) begin
			int_oe_n <= ~|irq;
		end
	end

	assign link.sda_dev_oe_n = sda_oe_n;
	assign gpio_out = drive_latch;
	assign gpio_oe_n = direction;
endmodule

// *** design/ioexp_host.sv ***
// Controller end: Avalon-MM registers driving a two-wire master
`timescale 1ns/1ps
`include "ioexp_cfg.svh"
module ioexp_host import ioexp_pkg::*; #(
	parameter int QUARTER_CYCLES = (`LINK_QUARTER_NS * 1000
		+ `CORE_PERIOD_PS - 1) / `CORE_PERIOD_PS
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	// Avalon-MM slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Two-wire link
	ioexp_if.host link
);
	// The expander needs a few cycles to see each scl edge
	if (QUARTER_CYCLES < 8 || QUARTER_CYCLES > 65535) begin : g_check
		$error("QUARTER_CYCLES must lie in 8..65535");
	end

	host_state_t hstate;
	logic [15:0] tick;
	logic [1:0] q;
	logic [2:0] idx;
	logic [3:0] bitn;
	logic [7:0] shift;
	logic [7:0] rxs;
	logic [6:0] target;
	logic [7:0] cmd_byte;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic busy;
	logic nack;
	logic op_read;
	logic [1:0] count;
	logic [1:0] next_count;
	logic scl_oe_n;
	logic sda_oe_n;
	logic sda_s;
	logic acc_wr;
	logic qtick;
	logic reading;
	logic [2:0] last_idx;

	sync2 #(.WIDTH(1), .INIT(1'b1)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.async_in(link.sda),
		.sync_out(sda_s)
	);

	assign acc_wr = write && !waitrequest;
	assign qtick = tick == 16'(QUARTER_CYCLES - 1);
	assign reading = op_read && idx >= 3'h3;
	assign last_idx = (op_read ? 3'h2 : 3'h1) + {1'b0, count};

	always_comb begin
		next_count = writedata[`CTRL_COUNT_LSB +: 2];
		if (next_count == 2'h3) begin
			next_count = 2'h2;
		end
		if (writedata[`CTRL_READ] && next_count == 2'h0) begin
			next_count = 2'h1;
		end
	end

	function automatic logic [7:0] byte_of(input logic [2:0] i);
		case (i)
			3'h0: byte_of = {target, `RW_WRITE};
			3'h1: byte_of = {5'h00, cmd_byte[2:0]};
			3'h2: byte_of = op_read ? {target, `RW_READ} : wdata[7:0];
			3'h3: byte_of = wdata[15:8];
			default: byte_of = 8'h00;
		endcase
	endfunction

	// One cycle answer: waitrequest drops for a single cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else if (ce) begin
			if ((read || write) && waitrequest) begin
				waitrequest <= 1'b0;
				case (address)
				`HOST_CTRL: readdata <= {28'h0, count, op_read, 1'b0};
				`HOST_TARGET: readdata <= {25'h0, target};
				`HOST_CMD: readdata <= {24'h0, cmd_byte};
				`HOST_WDATA: readdata <= {16'h0, wdata};
				`HOST_RDATA: readdata <= {16'h0, rdata};
				`HOST_STATUS: readdata <= {30'h0, nack, busy};
				default: readdata <= 32'h00000000;
				endcase
			end else begin
				waitrequest <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			target <= `RESET_TARGET;
			cmd_byte <= 8'h00;
			wdata <= 16'h0000;
		end else if (ce && acc_wr && !busy) begin
			case (address)
			`HOST_TARGET: target <= writedata[6:0];
			`HOST_CMD: cmd_byte <= writedata[7:0];
			`HOST_WDATA: wdata <= writedata[15:0];
			default: begin
			end
			endcase
		end
	end

	// Quarter-bit sequencer; samples sda just before pulling scl low
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			hstate <= H_IDLE;
			tick <= 16'h0000;
			q <= 2'h0;
			idx <= 3'h0;
			bitn <= 4'h0;
			shift <= 8'h00;
			rxs <= 8'h00;
			rdata <= 16'h0000;
			busy <= 1'b0;
			nack <= 1'b0;
			op_read <= 1'b0;
			count <= 2'h0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else if (ce) begin
			if (hstate == H_IDLE) begin
				tick <= 16'h0000;
				q <= 2'h0;
				if (acc_wr && address == `HOST_CTRL && writedata[`CTRL_GO]) begin
					busy <= 1'b1;
					nack <= 1'b0;
					op_read <= writedata[`CTRL_READ];
					count <= next_count;
					idx <= 3'h0;
					hstate <= H_START;
				end
			end else begin
				tick <= qtick ? 16'h0000 : tick + 16'h0001;
				if (qtick) begin
					q <= q + 2'h1;
					case (hstate)
					H_START: begin
						case (q)
						2'h0: sda_oe_n <= 1'b1;
						2'h1: scl_oe_n <= 1'b1;
						2'h2: sda_oe_n <= 1'b0;
						default: begin
							scl_oe_n <= 1'b0;
							bitn <= 4'h0;
							shift <= byte_of(idx);
							hstate <= H_BIT;
						end
						endcase
					end
					H_BIT: begin
						case (q)
						2'h0: begin
							if (bitn == 4'h8) begin
								sda_oe_n <= reading ? idx == last_idx : 1'b1;
							end else begin
								sda_oe_n <= reading ? 1'b1 : shift[7];
							end
						end
						2'h1: scl_oe_n <= 1'b1;
						2'h2: begin
						end
						default: begin
							scl_oe_n <= 1'b0;
							if (bitn != 4'h8) begin
								rxs <= {rxs[6:0], sda_s};
								shift <= {shift[6:0], 1'b0};
								bitn <= bitn + 4'h1;
							end else if (!reading && sda_s) begin
								nack <= 1'b1;
								hstate <= H_STOP;
							end else if (op_read && idx == 3'h1) begin
								idx <= 3'h2;
								hstate <= H_START;
							end else begin
								if (reading && idx == 3'h3) begin
									rdata[7:0] <= rxs;
								end else if (reading) begin
									rdata[15:8] <= rxs;
								end
								if (idx == last_idx) begin
									hstate <= H_STOP;
								end else begin
									idx <= idx + 3'h1;
									shift <= byte_of(idx + 3'h1);
									bitn <= 4'h0;
								end
							end
						end
						endcase
					end
					H_STOP: begin
						case (q)
						2'h0: sda_oe_n <= 1'b0;
						2'h1: scl_oe_n <= 1'b1;
						2'h2: sda_oe_n <= 1'b1;
						default: begin
							busy <= 1'b0;
							hstate <= H_IDLE;
						end
						endcase
					end
					default: hstate <= H_IDLE;
					endcase
				end
			end
		end
	end

	assign link.scl_oe_n = scl_oe_n;
	assign link.sda_host_oe_n = sda_oe_n;
endmodule

// *** verif/ioexp_link_properties.sv ***
// Wire-level checks on the two-wire link between controller and expander
`timescale 1ns/1ps
module ioexp_link_properties (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Link wires and drive enables
	input wire logic scl_oe_n,
	input wire logic sda_host_oe_n,
	input wire logic sda_dev_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic start_c;
	logic stop_c;
	int bits;
	assign start_c = scl & scl_q & sda_q & ~sda;
	assign stop_c = scl & scl_q & ~sda_q & sda;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// Clock rises since the last start; a restart clears it
	always_ff @(posedge core_clk) begin
		if (!nrst || start_c)
			bits <= 0;
		else if (scl && !scl_q)
			bits <= bits + 1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_start;
		start_c;
	endsequence
	sequence s_dev_low_rise;
		$rose(scl) && !sda_dev_oe_n;
	endsequence
	a_reset_release: assert property (disable iff (1'h0)
		!nrst |=> scl_oe_n && sda_host_oe_n && sda_dev_oe_n)
		else $error("link not released after reset");
	a_scl_high_hold: assert property ($rose(scl) |-> scl[*8])
		else $error("clock high phase too short");
	a_scl_low_hold: assert property ($fell(scl) |-> !scl[*8])
		else $error("clock low phase too short");
	a_dev_bit_hold: assert property (s_dev_low_rise |-> !sda_dev_oe_n[*8])
		else $error("expander let go of data while clock high");
	a_start_quiet: assert property (s_start |-> sda_dev_oe_n[*8])
		else $error("expander drives data during address");
	a_dev_edge_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
		else $error("expander changed data while clock high");
	a_sda_by_host: assert property (
		scl && scl_q && $changed(sda) |-> $changed(sda_host_oe_n))
		else $error("start or stop not made by controller");
	a_frame_bits: assert property (stop_c |-> bits % 9 == 1)
		else $error("frame not whole bytes with acknowledge");
endmodule

// *** verif/test_i2c_sixteen_bit_io_expander_regs.sv ***
// Self-checking bench for the controller and expander joined by the link
`timescale 1ns/1ps
`include "ioexp_cfg.svh"
module test_i2c_sixteen_bit_io_expander_regs import ioexp_pkg::*;;
	logic core_clk;
	logic nrst;
	logic [4:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] gpio_in;
	logic [15:0] gpio_out;
	logic [15:0] gpio_oe_n;
	logic [1:0] strap;
	logic int_oe_n;
	logic [31:0] rv;
	logic [15:0] rst_tab [3] = '{16'hFFFF, 16'h0000, 16'hFFFF};
	int num_errors;
	int checked;
	ioexp_if link ();
	// Short quarter keeps frames brief; bit timing scales with it
	ioexp_host #(.QUARTER_CYCLES(10)) ioexp_host_inst (.core_clk(core_clk),
		.nrst(nrst), .ce(1'h1), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .link(link));
	ioexp_device ioexp_device_inst (.core_clk(core_clk), .nrst(nrst),
		.ce(1'h1), .link(link), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe_n(gpio_oe_n), .addr_strap0(strap[0]),
		.addr_strap1(strap[1]), .int_oe_n(int_oe_n));
	ioexp_link_properties ioexp_link_properties_inst (.core_clk(core_clk),
		.nrst(nrst), .scl_oe_n(link.scl_oe_n),
		.sda_host_oe_n(link.sda_host_oe_n), .sda_dev_oe_n(link.sda_dev_oe_n),
		.scl(link.scl), .sda(link.sda));
	task automatic conclude();
		$display("Comparisons %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Outputs are flops, so right after an edge they still show that edge
	task automatic av(input logic rd, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		read <= rd;
		write <= ~rd;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 50);
		rv = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (n >= 50) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic xfer(input logic [6:0] tgt, input logic [7:0] cmd,
		input logic [15:0] wd, input logic rd, input logic [1:0] cnt);
		int n;
		n = 0;
		av(1'h0, `HOST_TARGET, {25'h0, tgt});
		av(1'h0, `HOST_CMD, {24'h0, cmd});
		av(1'h0, `HOST_WDATA, {16'h0, wd});
		av(1'h0, `HOST_CTRL, {28'h0, cnt, rd, 1'h1});
		do begin
			av(1'h1, `HOST_STATUS, 32'h0);
			n++;
		end while (rv[0] !== 1'h0 && n < 3000);
		if (n >= 3000) begin
			num_errors++;
			conclude();
		end
		if (rd)
			av(1'h1, `HOST_RDATA, 32'h0);
	endtask
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		nrst = 1'h0;
		read = 1'h0;
		write = 1'h0;
		address = 5'h00;
		writedata = 32'h0;
		gpio_in = 16'h0000;
		strap = 2'h0;
		num_errors = 0;
		checked = 0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge core_clk);
		cmp("enables", 16'hFFFF, gpio_oe_n);
		cmp("levels", 16'hFFFF, gpio_out);
		cmp("interrupt", 16'h0001, {15'h0, int_oe_n});
		for (int i = 0; i < 3; i++) begin
			xfer(7'h74, 8'(2 * i + 2), 16'h0000, 1'h1, 2'h2);
			cmp("reset value", rst_tab[i], rv[15:0]);
		end
		xfer(7'h74, 8'h03, 16'h3CA5, 1'h0, 2'h2);
		xfer(7'h74, 8'h06, 16'h0F00, 1'h0, 2'h2);
		cmp("levels", 16'hA53C, gpio_out);
		cmp("enables", 16'h0F00, gpio_oe_n);
		// Pins now differ from the latch, so a readback shows which it is
		xfer(7'h74, 8'h02, 16'h0000, 1'h1, 2'h2);
		cmp("latch readback", 16'hA53C, rv[15:0]);
		gpio_in <= 16'h1234;
		xfer(7'h74, 8'h04, 16'hFFFF, 1'h0, 2'h2);
		cmp("interrupt", 16'h0000, {15'h0, int_oe_n});
		xfer(7'h74, 8'h00, 16'h0000, 1'h1, 2'h1);
		cmp("low pins", 16'h0034, {8'h00, rv[7:0]});
		cmp("interrupt", 16'h0000, {15'h0, int_oe_n});
		xfer(7'h74, 8'h01, 16'h0000, 1'h1, 2'h2);
		cmp("pin levels", 16'h341D, rv[15:0]);
		cmp("interrupt", 16'h0001, {15'h0, int_oe_n});
		// An edge on an output pin must not raise the interrupt
		gpio_in <= 16'h12B4;
		xfer(7'h74, 8'h00, 16'hFFFF, 1'h0, 2'h2);
		cmp("interrupt", 16'h0001, {15'h0, int_oe_n});
		cmp("levels", 16'hA53C, gpio_out);
		cmp("enables", 16'h0F00, gpio_oe_n);
		xfer(7'h74, 8'h00, 16'h0000, 1'h1, 2'h2);
		cmp("pin levels", 16'h1DB4, rv[15:0]);
		for (int k = 0; k < 4; k++) begin
			strap <= k[1:0];
			xfer(7'h74 + 7'(k), 8'h02, {8'h00, 8'(k)}, 1'h0, 2'h1);
			cmp("strap address", {8'hA5, 8'(k)}, gpio_out);
		end
		xfer(7'h74, 8'h02, 16'h00FF, 1'h0, 2'h1);
		cmp("no answer", 16'h0002, rv[15:0]);
		cmp("levels", 16'hA503, gpio_out);
		conclude();
	end
endmodule
